// ---- hdl/relay_delay_timers.sv ----
// relay delay timers: off-delay, on/off-delay and retentive on-delay with apb registers
`timescale 1ns/10ps
module relay_delay_timers
  import relay_timers_pkg::*;
#(
  parameter int NUM_BLOCKS = 16,
  parameter int MS_CYCLES = MS_TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] trigger_input,
  input wire logic offd_clear_input,
  input wire logic ret_clear_input,
  input wire logic power_restore,
  input wire logic [NUM_BLOCKS-1:0][TIME_W-1:0] actual_values,
  output logic [2:0] switch_output
);

  // ***************************************************************
  // declarations
  // ***************************************************************
  // channel 0 is the off-delay timer, channel 1 the on/off-delay timer and
  // channel 2 the retentive on-delay timer; bit i of trigger_input and of
  // switch_output belongs to channel i throughout
  timer_cfg_s offd_cfg_q;
  timer_cfg_s onoff_cfg_q;
  timer_cfg_s ret_cfg_q;
  logic [TIME_W-1:0] offd_preset_q;
  logic [TIME_W-1:0] onoff_on_q;
  logic [TIME_W-1:0] onoff_off_q;
  logic [TIME_W-1:0] ret_preset_q;
  logic [TIME_W-1:0] offd_elapsed_q;
  logic [TIME_W-1:0] onoff_elapsed_q;
  logic [TIME_W-1:0] ret_elapsed_q;
  logic [TIME_W-1:0] offd_limit;
  logic [TIME_W-1:0] on_limit;
  logic [TIME_W-1:0] off_limit;
  logic [TIME_W-1:0] ret_limit;
  logic [2:0] trig_prev_q;
  logic [2:0] trig_rise;
  logic [2:0] trig_fall;
  logic [3:0] ticks;
  logic offd_tick;
  logic onoff_tick;
  logic ret_tick;
  logic offd_run_q;
  logic ret_run_q;
  onoff_state_e onoff_state_q;
  logic access;
  logic wr_en;
  logic [31:0] rd_val;
  logic rd_hit;

  // ***************************************************************
  // time base
  // ***************************************************************
  time_base_gen #(
    .MS_CYCLES(MS_CYCLES)
  ) u_time_base (
    .pclk(pclk),
    .presetn(presetn),
    .ticks(ticks)
  );

  // the dividers run freely from reset, so the first tick after a start may
  // come early by up to one base period; a base change takes effect at once
  // and a running count keeps its value, so reconfigure a channel only
  // while it is idle
  // each timer counts on its own selected base
  assign offd_tick = ticks[offd_cfg_q.base];
  assign onoff_tick = ticks[onoff_cfg_q.base];
  assign ret_tick = ticks[ret_cfg_q.base];

  // ***************************************************************
  // preset selection
  // ***************************************************************
  // picks fixed or borrowed value and clamps it to the range of the base;
  // an out-of-range block number reads as zero rather than wrapping
  // the clamp keeps a large borrowed value from giving a delay longer than
  // the base can show
  function automatic logic [TIME_W-1:0] pick_preset(
    input logic borrowed,
    input logic [3:0] blk,
    input logic [1:0] base,
    input logic [TIME_W-1:0] fixed,
    input logic [NUM_BLOCKS-1:0][TIME_W-1:0] vals
  );
    logic [TIME_W-1:0] raw;
    logic [TIME_W-1:0] lim;
    raw = fixed;
    lim = MAX_FIXED_10MS;
    if (borrowed) begin
      raw = (32'(blk) < NUM_BLOCKS) ? vals[blk] : PRESET_RESET;
      lim = (base == BASE_1MS) ? MAX_BORROW_MS : MAX_BORROW_UNIT;
    end else begin
      unique case (base)
        BASE_10MS: lim = MAX_FIXED_10MS;
        BASE_1MS: lim = MAX_FIXED_1MS;
        BASE_1S: lim = MAX_FIXED_1S;
        BASE_1MIN: lim = MAX_FIXED_1MIN;
      endcase
    end
    return (raw > lim) ? lim : raw;
  endfunction

  assign offd_limit = pick_preset(offd_cfg_q.src_a, offd_cfg_q.blk_a, offd_cfg_q.base,
                                  offd_preset_q, actual_values);
  assign on_limit = pick_preset(onoff_cfg_q.src_a, onoff_cfg_q.blk_a, onoff_cfg_q.base,
                                onoff_on_q, actual_values);
  assign off_limit = pick_preset(onoff_cfg_q.src_b, onoff_cfg_q.blk_b, onoff_cfg_q.base,
                                 onoff_off_q, actual_values);
  assign ret_limit = pick_preset(ret_cfg_q.src_a, ret_cfg_q.blk_a, ret_cfg_q.base,
                                 ret_preset_q, actual_values);

  // ***************************************************************
  // trigger edges
  // ***************************************************************
  // triggers come from logic on this clock, so no synchroniser is needed
  // the previous sample resets low: a trigger already high when reset is
  // released counts as a rising edge in the first cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_prev_q <= 3'h0;
    end else begin
      trig_prev_q <= trigger_input;
    end
  end

  assign trig_rise = trigger_input & ~trig_prev_q;
  assign trig_fall = ~trigger_input & trig_prev_q;

  // ***************************************************************
  // off-delay timer, channel 0
  // ***************************************************************
  // the tick branch comes last so an edge in a tick cycle restarts timing
  // a clear holds the channel idle while high; a fall seen just after the
  // clear is released starts a count with the output already low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_output[0] <= 1'b0;
      offd_run_q <= 1'b0;
      offd_elapsed_q <= PRESET_RESET;
    end else if (offd_clear_input || (power_restore && !offd_cfg_q.retentive)) begin
      switch_output[0] <= 1'b0;
      offd_run_q <= 1'b0;
      offd_elapsed_q <= PRESET_RESET;
    end else if (trig_rise[0]) begin
      switch_output[0] <= 1'b1;
      offd_run_q <= 1'b0;
      offd_elapsed_q <= PRESET_RESET;
    end else if (trig_fall[0]) begin
      offd_run_q <= 1'b1;
      offd_elapsed_q <= PRESET_RESET;
    end else if (offd_run_q && offd_tick) begin
      if (offd_elapsed_q + 17'h1 >= offd_limit) begin
        switch_output[0] <= 1'b0;
        offd_run_q <= 1'b0;
      end
      offd_elapsed_q <= offd_elapsed_q + 17'h1;
    end
  end

  // ***************************************************************
  // on/off-delay timer, channel 1
  // ***************************************************************
  // the trigger level, not its edge, decides each wait; elapsed restarts
  // at every state change so status always shows the current phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      onoff_state_q <= OO_IDLE;
      switch_output[1] <= 1'b0;
      onoff_elapsed_q <= PRESET_RESET;
    end else if (power_restore && !onoff_cfg_q.retentive) begin
      onoff_state_q <= OO_IDLE;
      switch_output[1] <= 1'b0;
      onoff_elapsed_q <= PRESET_RESET;
    end else begin
      unique case (onoff_state_q)
        OO_IDLE: begin
          if (trig_rise[1]) begin
            onoff_state_q <= OO_ON_WAIT;
            onoff_elapsed_q <= PRESET_RESET;
          end
        end
        OO_ON_WAIT: begin
          if (!trigger_input[1]) begin
            onoff_state_q <= OO_IDLE;
            onoff_elapsed_q <= PRESET_RESET;
          end else if (onoff_tick) begin
            if (onoff_elapsed_q + 17'h1 >= on_limit) begin
              onoff_state_q <= OO_HIGH;
              switch_output[1] <= 1'b1;
              onoff_elapsed_q <= PRESET_RESET;
            end else begin
              onoff_elapsed_q <= onoff_elapsed_q + 17'h1;
            end
          end
        end
        OO_HIGH: begin
          if (!trigger_input[1]) begin
            onoff_state_q <= OO_OFF_WAIT;
            onoff_elapsed_q <= PRESET_RESET;
          end
        end
        OO_OFF_WAIT: begin
          if (trigger_input[1]) begin
            onoff_state_q <= OO_HIGH;
            onoff_elapsed_q <= PRESET_RESET;
          end else if (onoff_tick) begin
            if (onoff_elapsed_q + 17'h1 >= off_limit) begin
              onoff_state_q <= OO_IDLE;
              switch_output[1] <= 1'b0;
              onoff_elapsed_q <= PRESET_RESET;
            end else begin
              onoff_elapsed_q <= onoff_elapsed_q + 17'h1;
            end
          end
        end
      endcase
    end
  end

  // ***************************************************************
  // retentive on-delay timer, channel 2
  // ***************************************************************
  // once started, the trigger is ignored until clear; output latches
  // power return clears the latch only when the retentive option is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_output[2] <= 1'b0;
      ret_run_q <= 1'b0;
      ret_elapsed_q <= PRESET_RESET;
    end else if (ret_clear_input || (power_restore && !ret_cfg_q.retentive)) begin
      switch_output[2] <= 1'b0;
      ret_run_q <= 1'b0;
      ret_elapsed_q <= PRESET_RESET;
    end else if (ret_run_q) begin
      if (ret_tick) begin
        if (ret_elapsed_q + 17'h1 >= ret_limit) begin
          switch_output[2] <= 1'b1;
          ret_run_q <= 1'b0;
        end
        ret_elapsed_q <= ret_elapsed_q + 17'h1;
      end
    end else if (trig_rise[2] && !switch_output[2]) begin
      ret_run_q <= 1'b1;
      ret_elapsed_q <= PRESET_RESET;
    end
  end

  // ***************************************************************
  // apb slave
  // ***************************************************************
  // one wait state: pready comes from a flop, so every answer takes the
  // second access cycle; this keeps read data registered as well
  assign access = psel && penable;
  assign wr_en = access && pready && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= access && !pready;
    end
  end

  // register writes land at the completing edge only
  // a master that leaves the access before pready is seen changes nothing,
  // which keeps a half-done transfer from disturbing a running timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offd_cfg_q <= CFG_RESET;
      onoff_cfg_q <= CFG_RESET;
      ret_cfg_q <= CFG_RESET;
      offd_preset_q <= PRESET_RESET;
      onoff_on_q <= PRESET_RESET;
      onoff_off_q <= PRESET_RESET;
      ret_preset_q <= PRESET_RESET;
    end else if (wr_en) begin
      unique case (paddr)
        OFFD_CFG_OFS: offd_cfg_q <= pwdata[CFG_W-1:0];
        OFFD_PRESET_OFS: offd_preset_q <= pwdata[TIME_W-1:0];
        ONOFF_CFG_OFS: onoff_cfg_q <= pwdata[CFG_W-1:0];
        ONOFF_ON_OFS: onoff_on_q <= pwdata[TIME_W-1:0];
        ONOFF_OFF_OFS: onoff_off_q <= pwdata[TIME_W-1:0];
        RET_CFG_OFS: ret_cfg_q <= pwdata[CFG_W-1:0];
        RET_PRESET_OFS: ret_preset_q <= pwdata[TIME_W-1:0];
        default: ; // status and elapsed are read-only
      endcase
    end
  end

  // read mux; reserved cfg bits always read zero
  // status packs outputs, run flags and the on/off state so software sees a
  // channel mid-count in one read instead of three
  always_comb begin
    rd_val = 32'h0;
    rd_hit = 1'b1;
    unique case (paddr)
      OFFD_CFG_OFS: rd_val = {16'h0, offd_cfg_q.blk_b, offd_cfg_q.blk_a, 3'h0,
                              offd_cfg_q[4:0]};
      OFFD_PRESET_OFS: rd_val = {15'h0, offd_preset_q};
      ONOFF_CFG_OFS: rd_val = {16'h0, onoff_cfg_q.blk_b, onoff_cfg_q.blk_a, 3'h0,
                               onoff_cfg_q[4:0]};
      ONOFF_ON_OFS: rd_val = {15'h0, onoff_on_q};
      ONOFF_OFF_OFS: rd_val = {15'h0, onoff_off_q};
      RET_CFG_OFS: rd_val = {16'h0, ret_cfg_q.blk_b, ret_cfg_q.blk_a, 3'h0,
                             ret_cfg_q[4:0]};
      RET_PRESET_OFS: rd_val = {15'h0, ret_preset_q};
      STATUS_OFS: rd_val = {24'h0, 1'b0, ret_run_q, onoff_state_q, offd_run_q,
                            switch_output};
      OFFD_ELAPSED_OFS: rd_val = {15'h0, offd_elapsed_q};
      ONOFF_ELAPSED_OFS: rd_val = {15'h0, onoff_elapsed_q};
      RET_ELAPSED_OFS: rd_val = {15'h0, ret_elapsed_q};
      default: rd_hit = 1'b0;
    endcase
  end

  // data and error are loaded with the ready pulse, zero otherwise
  // zeroing outside the answer cycle keeps stale data off the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (access && !pready) begin
      prdata <= (!pwrite && rd_hit) ? rd_val : 32'h0;
      pslverr <= !rd_hit;
    end else begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
  end

endmodule

// ---- hdl/relay_timers_pkg.sv ----
// package of constants, types and register map for the relay delay timers
package relay_timers_pkg;

  // ***************************************************************
  // clock and time base
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_TICK_NS = 1000000;
  localparam int MS_TICK_CYCLES = MS_TICK_NS / CLK_PERIOD_NS;
  localparam int MS_PER_10MS = 10;
  localparam int TEN_MS_PER_S = 100;
  localparam int S_PER_MIN = 60;

  // time base codes, also the index into the tick vector
  localparam logic [1:0] BASE_10MS = 2'h0;
  localparam logic [1:0] BASE_1MS = 2'h1;
  localparam logic [1:0] BASE_1S = 2'h2;
  localparam logic [1:0] BASE_1MIN = 2'h3;

  // ***************************************************************
  // preset limits, counted in units of the selected base
  // ***************************************************************
  localparam int TIME_W = 17;
  localparam logic [TIME_W-1:0] MAX_FIXED_10MS = 17'h0270f;
  localparam logic [TIME_W-1:0] MAX_FIXED_1S = 17'h0176f;
  localparam logic [TIME_W-1:0] MAX_FIXED_1MIN = 17'h0176f;
  localparam logic [TIME_W-1:0] MAX_FIXED_1MS = 17'h18696;
  localparam logic [TIME_W-1:0] MAX_BORROW_MS = 17'h18696;
  localparam logic [TIME_W-1:0] MAX_BORROW_UNIT = 17'h0176f;

  // ***************************************************************
  // register map, byte addresses
  // ***************************************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFFD_CFG_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] OFFD_PRESET_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] ONOFF_CFG_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] ONOFF_ON_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] ONOFF_OFF_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] RET_CFG_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] RET_PRESET_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h1c;
  localparam logic [ADDR_W-1:0] OFFD_ELAPSED_OFS = 8'h20;
  localparam logic [ADDR_W-1:0] ONOFF_ELAPSED_OFS = 8'h24;
  localparam logic [ADDR_W-1:0] RET_ELAPSED_OFS = 8'h28;

  // timer configuration word, bits 15:0 of each cfg register
  typedef struct packed {
    logic [3:0] blk_b;
    logic [3:0] blk_a;
    logic [2:0] rsv;
    logic src_b;
    logic src_a;
    logic retentive;
    logic [1:0] base;
  } timer_cfg_s;

  localparam int CFG_W = 16;
  localparam timer_cfg_s CFG_RESET = 16'h0000;
  localparam logic [TIME_W-1:0] PRESET_RESET = 17'h00000;

  // on/off delay sequencing
  typedef enum logic [1:0] {
    OO_IDLE = 2'b00,
    OO_ON_WAIT = 2'b01,
    OO_HIGH = 2'b10,
    OO_OFF_WAIT = 2'b11
  } onoff_state_e;

endpackage

// ---- hdl/time_base_gen.sv ----
// time base generator: 1 ms, 10 ms, 1 s and 1 min tick enables
`timescale 1ns/10ps
module time_base_gen
  import relay_timers_pkg::*;
#(
  parameter int MS_CYCLES = MS_TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic [3:0] ticks
);

  logic [31:0] div_q;
  logic [3:0] ten_q;
  logic [6:0] cs_q;
  logic [5:0] sec_q;
  logic ms_en;
  logic tenms_en;
  logic s_en;
  logic min_en;

  // cascade of enables; a slow tick always coincides with the faster ones
  assign ms_en = (div_q == 32'(MS_CYCLES - 1));
  assign tenms_en = ms_en && (ten_q == 4'(MS_PER_10MS - 1));
  assign s_en = tenms_en && (cs_q == 7'(TEN_MS_PER_S - 1));
  assign min_en = s_en && (sec_q == 6'(S_PER_MIN - 1));

  // *************************************************************
  // dividers
  // *************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 32'h0;
      ten_q <= 4'h0;
      cs_q <= 7'h0;
      sec_q <= 6'h0;
    end else begin
      div_q <= ms_en ? 32'h0 : div_q + 32'h1;
      if (ms_en) begin
        ten_q <= tenms_en ? 4'h0 : ten_q + 4'h1;
      end
      if (tenms_en) begin
        cs_q <= s_en ? 7'h0 : cs_q + 7'h1;
      end
      if (s_en) begin
        sec_q <= min_en ? 6'h0 : sec_q + 6'h1;
      end
    end
  end

  // registered ticks, indexed by base code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ticks <= 4'h0;
    end else begin
      ticks[BASE_10MS] <= tenms_en;
      ticks[BASE_1MS] <= ms_en;
      ticks[BASE_1S] <= s_en;
      ticks[BASE_1MIN] <= min_en;
    end
  end

endmodule

// ---- tb/block_values_model.sv ----
// model of the neighbouring function blocks that lend their actual values
`timescale 1ns/10ps
module block_values_model
  import relay_timers_pkg::*;
#(
  parameter int NUM_BLOCKS = 16
) (
  output logic [NUM_BLOCKS-1:0][TIME_W-1:0] actual_values
);
  // each neighbour holds its own block number; a steady value keeps the
  // borrowed preset predictable, at the cost of not testing a moving one
  always_comb begin
    for (int i = 0; i < NUM_BLOCKS; i++) begin
      actual_values[i] = TIME_W'(i);
    end
  end
endmodule

// ---- tb/relay_delay_timers_test.sv ----
// self-checking testbench for the relay delay timers
`timescale 1ns/10ps
module relay_delay_timers_test
  import relay_timers_pkg::*;
;
  localparam int NB = 16;
  localparam int LIMIT = 20000;
  typedef struct {logic [7:0] a; logic [31:0] wd; logic [31:0] rd; logic err;} row_s;
  // ***************************************************************
  // register rows: write value, expected read back, expected error
  // ***************************************************************
  row_s rows[9] = '{'{8'h00, 32'hffffffff, 32'h0000ff1f, 1'b0},
    '{8'h04, 32'h00000123, 32'h00000123, 1'b0}, '{8'h08, 32'h0000a5a5, 32'h0000a505, 1'b0},
    '{8'h0c, 32'h00000456, 32'h00000456, 1'b0}, '{8'h10, 32'h00000789, 32'h00000789, 1'b0},
    '{8'h14, 32'h00005a5a, 32'h00005a1a, 1'b0}, '{8'h18, 32'h00000abc, 32'h00000abc, 1'b0},
    '{8'h20, 32'hffffffff, 32'h00000000, 1'b0}, '{8'h2c, 32'h00000001, 32'h00000000, 1'b1}};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] trigger_input = 3'h0;
  logic offd_clear_input = 1'b0;
  logic ret_clear_input = 1'b0;
  logic power_restore = 1'b0;
  logic [NB-1:0][TIME_W-1:0] actual_values;
  logic [2:0] switch_output;
  logic [31:0] rd;
  logic er;
  int n;
  int cycles = 0;
  int bad_count = 0;
  int total_checks = 0;

  always #25 pclk = ~pclk;

  block_values_model #(.NUM_BLOCKS(NB)) u_blocks (.actual_values(actual_values));
  relay_delay_timers #(.NUM_BLOCKS(NB), .MS_CYCLES(4)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .trigger_input(trigger_input),
    .offd_clear_input(offd_clear_input), .ret_clear_input(ret_clear_input),
    .power_restore(power_restore), .actual_values(actual_values),
    .switch_output(switch_output));

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // cut a hang short: counts as a mismatch
  always @(posedge pclk) begin
    cycles++;
    if (cycles >= LIMIT) begin
      bad_count++;
      final_report();
    end
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_range(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // wait for an output level, cycles spent left in n
  task automatic wait_out(input int i, input logic v);
    n = 0;
    while (switch_output[i] !== v && n < 200) begin
      @(posedge pclk);
      n++;
    end
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 40; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      chk_word(rd, 32'h0);
    end
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].wd);
      apb(1'b0, rows[i].a, 32'h0);
      chk_word(rd, rows[i].rd);
      chk_word({31'h0, er}, {31'h0, rows[i].err});
    end
    $display("register test done");
    // 1 ms base, preset 5 everywhere, only the retentive channel keeps state
    apb(1'b1, OFFD_CFG_OFS, 32'h1);
    apb(1'b1, OFFD_PRESET_OFS, 32'h5);
    apb(1'b1, ONOFF_CFG_OFS, 32'h1);
    apb(1'b1, ONOFF_ON_OFS, 32'h5);
    apb(1'b1, ONOFF_OFF_OFS, 32'h5);
    apb(1'b1, RET_CFG_OFS, 32'h5);
    apb(1'b1, RET_PRESET_OFS, 32'h5);
    trigger_input[0] <= 1'b1;
    repeat (4) @(posedge pclk);
    chk_word({31'h0, switch_output[0]}, 32'h1);
    trigger_input[0] <= 1'b0;
    repeat (12) @(posedge pclk);
    trigger_input[0] <= 1'b1;
    repeat (2) @(posedge pclk);
    trigger_input[0] <= 1'b0;
    wait_out(0, 1'b0);
    chk_range(n, 16, 26);
    trigger_input[0] <= 1'b1;
    repeat (4) @(posedge pclk);
    trigger_input[0] <= 1'b0;
    repeat (4) @(posedge pclk);
    trigger_input[0] <= 1'b1;
    offd_clear_input <= 1'b1;
    repeat (2) @(posedge pclk);
    chk_word({31'h0, switch_output[0]}, 32'h0);
    apb(1'b0, OFFD_ELAPSED_OFS, 32'h0);
    chk_word(rd, 32'h0);
    offd_clear_input <= 1'b0;
    trigger_input[0] <= 1'b0;
    $display("off-delay test done");
    trigger_input[1] <= 1'b1;
    repeat (8) @(posedge pclk);
    trigger_input[1] <= 1'b0;
    repeat (30) @(posedge pclk);
    chk_word({31'h0, switch_output[1]}, 32'h0);
    trigger_input[1] <= 1'b1;
    wait_out(1, 1'b1);
    chk_range(n, 16, 26);
    trigger_input[1] <= 1'b0;
    repeat (8) @(posedge pclk);
    trigger_input[1] <= 1'b1;
    repeat (30) @(posedge pclk);
    chk_word({31'h0, switch_output[1]}, 32'h1);
    trigger_input[1] <= 1'b0;
    wait_out(1, 1'b0);
    chk_range(n, 16, 26);
    $display("on/off-delay test done");
    trigger_input[2] <= 1'b1;
    repeat (2) @(posedge pclk);
    trigger_input[2] <= 1'b0;
    wait_out(2, 1'b1);
    chk_range(n, 13, 26);
    trigger_input[2] <= 1'b1;
    repeat (2) @(posedge pclk);
    trigger_input[2] <= 1'b0;
    repeat (30) @(posedge pclk);
    chk_word({31'h0, switch_output[2]}, 32'h1);
    apb(1'b0, RET_ELAPSED_OFS, 32'h0);
    chk_word(rd, 32'h5);
    // power returns: off-delay forgets, retentive channel keeps its latch
    trigger_input[0] <= 1'b1;
    repeat (4) @(posedge pclk);
    power_restore <= 1'b1;
    @(posedge pclk);
    power_restore <= 1'b0;
    repeat (2) @(posedge pclk);
    chk_word({29'h0, switch_output[2], 1'b0, switch_output[0]}, 32'h4);
    trigger_input[0] <= 1'b0;
    trigger_input[2] <= 1'b1;
    ret_clear_input <= 1'b1;
    repeat (2) @(posedge pclk);
    chk_word({31'h0, switch_output[2]}, 32'h0);
    apb(1'b0, RET_ELAPSED_OFS, 32'h0);
    chk_word(rd, 32'h0);
    ret_clear_input <= 1'b0;
    trigger_input[2] <= 1'b0;
    $display("retentive test done");
    // borrowed preset: block 2 lends 2, fixed 9 would be far slower
    apb(1'b1, OFFD_PRESET_OFS, 32'h9);
    apb(1'b1, OFFD_CFG_OFS, 32'h0209);
    trigger_input[0] <= 1'b1;
    repeat (4) @(posedge pclk);
    trigger_input[0] <= 1'b0;
    wait_out(0, 1'b0);
    chk_range(n, 4, 14);
    // 10 ms base, fixed preset 2: two slow ticks of 40 cycles each
    apb(1'b1, OFFD_PRESET_OFS, 32'h2);
    apb(1'b1, OFFD_CFG_OFS, 32'h0);
    trigger_input[0] <= 1'b1;
    repeat (4) @(posedge pclk);
    trigger_input[0] <= 1'b0;
    wait_out(0, 1'b0);
    chk_range(n, 40, 90);
    $display("borrowed preset test done");
    final_report();
  end
endmodule

// ---- tb/relay_timers_checker.sv ----
// assertion checker for the relay delay timers, bound to the top module
`timescale 1ns/10ps
module relay_timers_checker
  import relay_timers_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] trigger_input,
  input wire logic offd_clear_input,
  input wire logic ret_clear_input,
  input wire logic power_restore,
  input wire logic [2:0] switch_output
);
  // ***************************************************************
  // single clock domain, reset disables every check
  // ***************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // access cycle still waiting for the slave
  sequence apb_wait_s;
    psel && penable && !pready;
  endsequence
  // clean rise on the off-delay trigger, no clear for two samples
  sequence offd_rise_s;
    $rose(trigger_input[0]) && !offd_clear_input && !power_restore
      ##1 !offd_clear_input && !power_restore;
  endsequence

  apb_wait_a: assert property (apb_wait_s |=> pready) else $error("missing ready");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  offd_rise_a: assert property (offd_rise_s |-> ##[0:1] switch_output[0])
    else $error("off-delay output did not rise");
  offd_hold_a: assert property ($fell(trigger_input[0]) && switch_output[0]
    && !offd_clear_input && !power_restore |=> switch_output[0]) else $error("output dropped");
  // an expiry needs at least one tick with the trigger low, so two low samples
  offd_expire_a: assert property ($fell(switch_output[0]) |->
    (!$past(trigger_input[0]) && !$past(trigger_input[0], 2)) || $past(offd_clear_input)
    || $past(power_restore)) else $error("off-delay fell too early");
  offd_clear_a: assert property (offd_clear_input |=> !switch_output[0])
    else $error("off-delay clear ignored");
  onoff_rise_a: assert property ($rose(switch_output[1]) |->
    $past(trigger_input[1]) && $past(trigger_input[1], 2)) else $error("on/off rose early");
  onoff_fall_a: assert property ($fell(switch_output[1]) |->
    (!$past(trigger_input[1]) && !$past(trigger_input[1], 2)) || $past(power_restore))
    else $error("on/off fell early");
  ret_latch_a: assert property (switch_output[2] && !ret_clear_input && !power_restore
    |=> switch_output[2]) else $error("retentive output lost");
  ret_clear_a: assert property (ret_clear_input |=> !switch_output[2])
    else $error("retentive clear ignored");
endmodule

bind relay_delay_timers relay_timers_checker u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .trigger_input(trigger_input), .offd_clear_input(offd_clear_input),
  .ret_clear_input(ret_clear_input), .power_restore(power_restore),
  .switch_output(switch_output));
